// ### rtl/pm_control_and_timer.sv
/*
  power management control register and free-running timer.
  assumes a byte-enabled register port on the core clock, pins that are
  asynchronous to it, and enable/clear strobes from neighbouring logic.
*/
// Function
// - route bit one sends events as os interrupt, zero as firmware interrupt.
// - only hardware strobes set or clear the route bit.
// - bus-master wake bit one: bus-master request wakes C3 processors to C0.
// - bus-master wake bit zero: requests leave C3 processors alone.
// - global lock release is write-only; writing one raises firmware interrupt.
// - firmware has its own enable and status pair for lock release events.
// - three-bit sleep type field at bits 10 to 12 picks sleep state.
// - sleep trigger bit 13 is write-only and reads zero.
// - writing sleep trigger one starts sequencing into programmed sleep type.
// - control bits 14 and 15 read zero.
// - control register takes byte and word accesses only.
// - control register resets to zero, read-write except route bit, write-only and reserved.
// - control bits may be split over two instances at aligned addresses.
// - timer counts at 3.579545 MHz, at least 24 bits, while working.
// - carry status sets whenever the top implemented timer bit toggles.
// - timer start value arbitrary; not reset on entering working state.
// - timer holds while base clock stops and resumes from held value.
// - timer bits 24 to 31 hold upper count, or zero when 24-bit.
// - width flag tells whether the timer is 32 or 24 bits.
// - timer register is read-only, resets to zero, read as 32 bits.
// - timer enable one raises os interrupt while carry status is set and route bit is one, else firmware interrupt.
// - split instance reads zero for other instance bits; writes harmless.
`timescale 1ns/1ps
module pm_control_and_timer #(
  parameter logic [15:0] IMPL_MASK  = pm_pkg::CTRL_ALL_MASK,
  parameter logic        TIMER_WIDE = 1'b1
) (
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        reg_addr_i,
  input  wire logic [3:0]  reg_be_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [31:0] reg_wdata_i,
  output logic [31:0]      reg_rdata_o,
  output logic             reg_rvalid_o,
  input  wire logic        route_set_i,
  input  wire logic        route_clr_i,
  input  wire logic        pm_event_i,
  input  wire logic        busmaster_req_i,
  input  wire logic        cpu_in_c3_i,
  output logic             c3_wake_o,
  input  wire logic        firmware_event_enable_i,
  input  wire logic        firmware_event_clr_i,
  output logic             firmware_event_status_o,
  input  wire logic        timer_interrupt_enable_i,
  input  wire logic        timer_status_clr_i,
  output logic             timer_carry_status_o,
  input  wire logic        base_clk_run_i,
  input  wire logic        wake_i,
  output logic             sleep_req_o,
  output logic [2:0]       sleep_type_o,
  output logic             sleeping_o,
  output logic             timer_width_flag_o,
  output logic             os_level_interrupt_o,
  output logic             firmware_management_interrupt_o
);

  localparam int SYNC_N = 3;

  logic [15:0]        ctrl;
  logic [31:0]        count;
  logic               msb_last;
  logic               tick;
  logic               run;
  logic [SYNC_N-1:0]  pin_meta;
  logic [SYNC_N-1:0]  pin_sync;
  logic               bm_req;
  logic               wake;
  logic               clk_run;
  logic               ctrl_wr;
  logic               timer_wr;
  logic [15:0]        wr_lanes;
  logic [15:0]        next_ctrl;
  logic               glr_pulse;
  logic               trig_pulse;
  logic               msb_now;
  logic               pm_any;
  logic [31:0]        timer_view;
  pm_pkg::sleep_state_t state;
  pm_pkg::sleep_state_t next_state;

  // expands the two low byte enables into a 16-bit lane mask
  function automatic logic [15:0] lane_mask(input logic [3:0] be);
    lane_mask = {{8{be[pm_pkg::LANE1]}}, {8{be[pm_pkg::LANE0]}}};
  endfunction : lane_mask

  // true when a write or read of one lane touches the given bit
  function automatic logic hits_bit(input logic [3:0] be, input int pos);
    logic [15:0] m;
    m = lane_mask(be);
    hits_bit = m[pos];
  endfunction : hits_bit

  // two-stage synchronisers for pins
  genvar g;
  generate
    for (g = 0; g < SYNC_N; g++) begin : g_sync
      always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
          pin_meta[g] <= 1'b0;
          pin_sync[g] <= 1'b0;
        end else begin
          pin_meta[g] <= (g == 0) ? busmaster_req_i :
                         (g == 1) ? wake_i : base_clk_run_i;
          pin_sync[g] <= pin_meta[g];
        end
      end
    end
  endgenerate

  assign bm_req  = pin_sync[0];
  assign wake    = pin_sync[1];
  assign clk_run = pin_sync[2];

  assign ctrl_wr  = reg_wr_i && (reg_addr_i == pm_pkg::CTRL_INDEX);
  assign timer_wr = reg_wr_i && (reg_addr_i == pm_pkg::TIMER_INDEX);
  assign wr_lanes = lane_mask(reg_be_i) & IMPL_MASK;

  // write-only strobes, never stored
  assign glr_pulse  = ctrl_wr && hits_bit(reg_be_i, pm_pkg::GLR_BIT)
                      && IMPL_MASK[pm_pkg::GLR_BIT]
                      && reg_wdata_i[pm_pkg::GLR_BIT];
  assign trig_pulse = ctrl_wr && hits_bit(reg_be_i, pm_pkg::STRIG_BIT)
                      && IMPL_MASK[pm_pkg::STRIG_BIT]
                      && reg_wdata_i[pm_pkg::STRIG_BIT];

  always_comb begin
    next_ctrl = ctrl;
    if (ctrl_wr) begin
      next_ctrl = (ctrl & ~(wr_lanes & pm_pkg::CTRL_SW_MASK)) |
                  (reg_wdata_i[15:0] & wr_lanes & pm_pkg::CTRL_SW_MASK);
    end
    // route bit moves only by hardware; set wins over clear
    if (IMPL_MASK[pm_pkg::ROUTE_BIT]) begin
      if (route_set_i) begin
        next_ctrl[pm_pkg::ROUTE_BIT] = 1'b1;
      end else if (route_clr_i) begin
        next_ctrl[pm_pkg::ROUTE_BIT] = 1'b0;
      end
    end
  end

  // control register
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      ctrl <= pm_pkg::CTRL_RESET;
    end else begin
      ctrl <= next_ctrl;
    end
  end

  // firmware status for lock release events, set wins over clear
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      firmware_event_status_o <= 1'b0;
    end else if (glr_pulse) begin
      firmware_event_status_o <= 1'b1;
    end else if (firmware_event_clr_i) begin
      firmware_event_status_o <= 1'b0;
    end
  end

  // sleep sequencing
  always_comb begin
    next_state = state;
    case (state)
      pm_pkg::ST_WORK:  if (trig_pulse) next_state = pm_pkg::ST_SEQ;
      pm_pkg::ST_SEQ:   next_state = pm_pkg::ST_SLEEP;
      pm_pkg::ST_SLEEP: if (wake) next_state = pm_pkg::ST_WORK;
      default:          next_state = pm_pkg::ST_WORK;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      state <= pm_pkg::ST_WORK;
    end else begin
      state <= next_state;
    end
  end

  // sleep type latched from the field as written with the trigger
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      sleep_type_o <= '0;
    end else if (trig_pulse) begin
      sleep_type_o <= next_ctrl[pm_pkg::STYPE_HI:pm_pkg::STYPE_LO];
    end
  end

  assign sleep_req_o = (state == pm_pkg::ST_SEQ);
  assign sleeping_o  = (state == pm_pkg::ST_SLEEP);

  // timer runs only in working state with the base clock alive
  assign run = clk_run && (state == pm_pkg::ST_WORK);

  pm_timer_tick u_tick (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .run_i      (run),
    .tick_o     (tick)
  );

  // counter is never written by software and not cleared on wake
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      count <= pm_pkg::TIMER_RESET;
    end else if (tick && run) begin
      count <= count + 32'h0000_0001;
    end
  end

  assign msb_now = TIMER_WIDE ? count[pm_pkg::MSB_WIDE] : count[pm_pkg::MSB_NARROW];

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      msb_last <= 1'b0;
    end else begin
      msb_last <= msb_now;
    end
  end

  // carry status, set wins over clear
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      timer_carry_status_o <= 1'b0;
    end else if (msb_now != msb_last) begin
      timer_carry_status_o <= 1'b1;
    end else if (timer_status_clr_i) begin
      timer_carry_status_o <= 1'b0;
    end
  end

  assign timer_view = count & (TIMER_WIDE ? pm_pkg::ALL32_MASK
                                          : pm_pkg::LOW24_MASK);
  assign timer_width_flag_o = TIMER_WIDE;

  // read data registered; write-only and reserved bits read zero
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      reg_rdata_o  <= '0;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i) begin
        if (reg_addr_i == pm_pkg::CTRL_INDEX) begin
          reg_rdata_o <= {16'h0000, ctrl & pm_pkg::CTRL_RD_MASK & IMPL_MASK
                          & lane_mask(reg_be_i)};
        end else begin
          reg_rdata_o <= timer_view;
        end
      end
    end
  end

  // bus-master wake gated by the enable bit
  assign c3_wake_o = ctrl[pm_pkg::BMWAKE_BIT] && bm_req && cpu_in_c3_i;

  // event routing; an enabled timer carry is one more management event
  assign pm_any = pm_event_i || (timer_interrupt_enable_i && timer_carry_status_o);
  assign os_level_interrupt_o = ctrl[pm_pkg::ROUTE_BIT] && pm_any;
  assign firmware_management_interrupt_o =
    (!ctrl[pm_pkg::ROUTE_BIT] && pm_any) ||
    (firmware_event_enable_i && firmware_event_status_o);

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_trigger;
    trig_pulse && state == pm_pkg::ST_WORK;
  endsequence

  sequence s_enter_sleep;
    sleep_req_o ##1 sleeping_o;
  endsequence

  a_route_os_event: assert property (
    ctrl[pm_pkg::ROUTE_BIT] && pm_event_i |-> os_level_interrupt_o)
    else $error("event not routed to os interrupt");

  a_route_fw_event: assert property (
    !ctrl[pm_pkg::ROUTE_BIT] && pm_event_i |->
      firmware_management_interrupt_o && !os_level_interrupt_o)
    else $error("event not routed to firmware interrupt");

  a_route_sw_hold: assert property (
    !route_set_i && !route_clr_i |=> $stable(ctrl[pm_pkg::ROUTE_BIT]))
    else $error("route bit moved without hardware strobe");

  a_bm_wake_gate: assert property (
    ctrl[pm_pkg::BMWAKE_BIT] && bm_req && cpu_in_c3_i |-> c3_wake_o)
    else $error("bus-master request did not wake C3");

  a_bm_wake_off: assert property (
    !ctrl[pm_pkg::BMWAKE_BIT] |-> !c3_wake_o)
    else $error("C3 wake while wake bit clear");

  a_glr_fw_irq: assert property (
    glr_pulse && firmware_event_enable_i ##1 firmware_event_enable_i
      |-> firmware_event_status_o && firmware_management_interrupt_o)
    else $error("lock release raised no firmware interrupt");

  a_ctrl_read_zero: assert property (
    reg_rd_i && reg_addr_i == pm_pkg::CTRL_INDEX |=>
      reg_rvalid_o && reg_rdata_o[31:pm_pkg::STRIG_BIT] == '0)
    else $error("write-only or reserved control bits read nonzero");

  a_sleep_seq: assert property (
    s_trigger |=> s_enter_sleep)
    else $error("sleep trigger did not start sequencing");

  a_sleep_type: assert property (
    s_trigger |=> sleep_type_o == ctrl[pm_pkg::STYPE_HI:pm_pkg::STYPE_LO])
    else $error("sleep type not taken from field");

  a_timer_hold: assert property (
    !run |=> $stable(count))
    else $error("timer moved while stopped");

  a_timer_ignore_wr: assert property (
    timer_wr && !tick |=> $stable(count))
    else $error("timer write changed count");

  a_carry_set: assert property (
    msb_now != msb_last |=> timer_carry_status_o)
    else $error("carry status missed top bit toggle");

  a_carry_quiet: assert property (
    !timer_carry_status_o && msb_now == msb_last |=> !timer_carry_status_o)
    else $error("carry status set without top bit toggle");

  a_timer_irq: assert property (
    ctrl[pm_pkg::ROUTE_BIT] && timer_interrupt_enable_i && timer_carry_status_o
      |-> os_level_interrupt_o)
    else $error("timer carry raised no os interrupt");

endmodule : pm_control_and_timer

// ### rtl/pm_pkg.sv
/*
  shared constants for the power management control and timer block:
  register indices, control field positions, masks, reset values and clock rates.
  assumes one 100 MHz core clock and a simple byte-enabled register port.
*/
package pm_pkg;

  // register indices on the register port
  localparam logic       CTRL_INDEX  = 1'h0;
  localparam logic       TIMER_INDEX = 1'h1;

  // control register field positions
  localparam int         ROUTE_BIT   = 0;
  localparam int         BMWAKE_BIT  = 1;
  localparam int         GLR_BIT     = 2;
  localparam int         STYPE_LO    = 10;
  localparam int         STYPE_HI    = 12;
  localparam int         STRIG_BIT   = 13;
  localparam int         STYPE_W     = 3;

  // bits that software may change, and bits that read back
  localparam logic [15:0] CTRL_SW_MASK  = 16'h1C02;
  localparam logic [15:0] CTRL_RD_MASK  = 16'h1C03;
  localparam logic [15:0] CTRL_ALL_MASK = 16'hFFFF;
  localparam logic [15:0] CTRL_RESET    = 16'h0000;
  localparam logic [31:0] TIMER_RESET   = 32'h0000_0000;
  localparam logic [31:0] LOW24_MASK    = 32'h00FF_FFFF;
  localparam logic [31:0] ALL32_MASK    = 32'hFFFF_FFFF;

  // byte lanes
  localparam int         LANE0 = 0;
  localparam int         LANE1 = 1;
  localparam logic [3:0] BE_WORD32 = 4'hF;

  // timer word widths
  localparam int         TIMER_W   = 32;
  localparam int         MSB_NARROW = 23;
  localparam int         MSB_WIDE   = 31;

  // clock rates for the timer tick generator
  localparam int         CORE_HZ  = 100000000;
  localparam int         TIMER_HZ = 3579545;
  localparam int         ACC_W    = 27;

  typedef enum logic [1:0] {
    ST_WORK,
    ST_SEQ,
    ST_SLEEP
  } sleep_state_t;

endpackage : pm_pkg

// ### rtl/pm_timer_tick.sv
/*
  fractional divider giving a one-cycle enable at the timer rate.
  assumes core_clk_i at pm_pkg::CORE_HZ; run_i low freezes the phase.
*/
`timescale 1ns/1ps
module pm_timer_tick (
  input  wire logic core_clk_i,
  input  wire logic rst_n_i,
  input  wire logic run_i,
  output logic      tick_o
);

  localparam logic [pm_pkg::ACC_W-1:0] STEP =
    pm_pkg::ACC_W'(pm_pkg::TIMER_HZ);
  localparam logic [pm_pkg::ACC_W-1:0] WRAP =
    pm_pkg::ACC_W'(pm_pkg::CORE_HZ);

  logic [pm_pkg::ACC_W-1:0] phase;
  logic [pm_pkg::ACC_W-1:0] next_phase;
  logic                     next_tick;

  always_comb begin
    next_phase = phase + STEP;
    next_tick  = 1'b0;
    if (next_phase >= WRAP) begin
      next_phase = next_phase - WRAP;
      next_tick  = 1'b1;
    end
  end

  // phase holds while the base clock is stopped so counting resumes in step
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      phase  <= '0;
      tick_o <= 1'b0;
    end else if (run_i) begin
      phase  <= next_phase;
      tick_o <= next_tick;
    end else begin
      tick_o <= 1'b0;
    end
  end

endmodule : pm_timer_tick

// ### test/pm_control_and_timer_test.sv
/*
  self-checking bench for the power management control register and timer.
  assumes the design's register port, 100 MHz core clock and synchronous active-low reset.
*/
`timescale 1ns/1ps
module pm_control_and_timer_test;
  typedef struct packed {
    logic [3:0]  bw;
    logic [15:0] d;
    logic [3:0]  br;
    logic [15:0] exp;
  } row_t;
  localparam row_t ROWS [6] = '{
    '{4'h3, 16'hDFFE, 4'h3, 16'h1C02}, '{4'h1, 16'h0000, 4'h3, 16'h1C00},
    '{4'h2, 16'h0C00, 4'h3, 16'h0C00}, '{4'h3, 16'h0402, 4'h1, 16'h0002},
    '{4'h3, 16'h0402, 4'h2, 16'h0400}, '{4'h3, 16'h0000, 4'h3, 16'h0000}};
  logic        core_clk_i, rst_n_i, reg_addr_i, reg_wr_i, reg_rd_i;
  logic [3:0]  reg_be_i;
  logic [31:0] reg_wdata_i, reg_rdata_o, q, t0, t1;
  logic        reg_rvalid_o, route_set_i, route_clr_i, pm_event_i, busmaster_req_i;
  logic        cpu_in_c3_i, c3_wake_o, firmware_event_enable_i, firmware_event_clr_i;
  logic        firmware_event_status_o, timer_interrupt_enable_i, timer_status_clr_i;
  logic        timer_carry_status_o, base_clk_run_i, wake_i, sleep_req_o, sleeping_o;
  logic [2:0]  sleep_type_o;
  logic        timer_width_flag_o, os_level_interrupt_o, firmware_management_interrupt_o;
  int          n_fail, cmp_count;

`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected %s expected %h seen %h", nm, e, g); end end

  pm_control_and_timer dut (.*);

  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish

  task automatic wr(input logic a, input logic [3:0] be, input logic [31:0] d);
    @(posedge core_clk_i);
    reg_addr_i  <= a;
    reg_be_i    <= be;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i    <= 1'b0;
  endtask : wr

  task automatic rd(input logic a, input logic [3:0] be, output logic [31:0] r);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_be_i   <= be;
    reg_rd_i   <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_i   <= 1'b0;
    #1;
    `CHK("rvalid", 1'b1, reg_rvalid_o)
    r = reg_rdata_o;
    @(posedge core_clk_i);
  endtask : rd

  function automatic logic sel(input int w);
    case (w)
      0: sel = sleep_req_o;
      1: sel = sleeping_o;
      default: sel = c3_wake_o;
    endcase
  endfunction : sel

  // bounded wait for a design output to reach a level
  task automatic wait_on(input int w, input logic lvl);
    int k;
    k = 0;
    #1;
    while (sel(w) !== lvl && k < 50) begin
      @(posedge core_clk_i);
      #1;
      k++;
    end
    if (sel(w) !== lvl) begin
      n_fail++;
      $display("unexpected wait %0d expected %b seen %b", w, lvl, sel(w));
      tally_and_finish();
    end
  endtask : wait_on

  task automatic pulse_route(input logic set);
    @(posedge core_clk_i);
    if (set) route_set_i <= 1'b1;
    else route_clr_i <= 1'b1;
    @(posedge core_clk_i);
    route_set_i <= 1'b0;
    route_clr_i <= 1'b0;
    #1;
  endtask : pulse_route

  initial begin
    {rst_n_i, reg_addr_i, reg_wr_i, reg_rd_i, route_set_i, route_clr_i} = '0;
    {pm_event_i, busmaster_req_i, cpu_in_c3_i, firmware_event_enable_i} = '0;
    {firmware_event_clr_i, timer_interrupt_enable_i, timer_status_clr_i, wake_i} = '0;
    reg_be_i = 4'h0;
    reg_wdata_i = 32'h0000_0000;
    base_clk_run_i = 1'b1;
    n_fail = 0;
    cmp_count = 0;
    repeat (3) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    rd(1'b0, 4'h3, q);
    `CHK("ctrl_reset", 32'h0000_0000, q)
    rd(1'b1, 4'hF, q);
    `CHK("timer_reset", 32'h0000_0000, q)
    `CHK("width_flag", 1'b1, timer_width_flag_o)
    $display("test reset done");
    foreach (ROWS[i]) begin
      wr(1'b0, ROWS[i].bw, {16'h0000, ROWS[i].d});
      rd(1'b0, ROWS[i].br, q);
      `CHK("ctrl_row", {16'h0000, ROWS[i].exp}, q)
    end
    $display("test rows done");
    pm_event_i <= 1'b1;
    @(posedge core_clk_i);
    #1;
    `CHK("fw_int_route0", 1'b1, firmware_management_interrupt_o)
    `CHK("os_int_route0", 1'b0, os_level_interrupt_o)
    pulse_route(1'b1);
    `CHK("os_int_route1", 1'b1, os_level_interrupt_o)
    `CHK("fw_int_route1", 1'b0, firmware_management_interrupt_o)
    wr(1'b0, 4'h3, 32'h0000_0000);
    rd(1'b0, 4'h3, q);
    `CHK("route_kept", 32'h0000_0001, q)
    pulse_route(1'b0);
    rd(1'b0, 4'h3, q);
    `CHK("route_cleared", 32'h0000_0000, q)
    pm_event_i <= 1'b0;
    $display("test route done");
    firmware_event_clr_i <= 1'b1;
    firmware_event_enable_i <= 1'b1;
    @(posedge core_clk_i);
    firmware_event_clr_i <= 1'b0;
    @(posedge core_clk_i);
    #1;
    `CHK("fw_sts_clear", 1'b0, firmware_event_status_o)
    `CHK("fw_int_idle", 1'b0, firmware_management_interrupt_o)
    wr(1'b0, 4'h1, 32'h0000_0004);
    @(posedge core_clk_i);
    #1;
    `CHK("fw_sts_set", 1'b1, firmware_event_status_o)
    `CHK("fw_int_lock", 1'b1, firmware_management_interrupt_o)
    rd(1'b0, 4'h3, q);
    `CHK("lock_reads_zero", 32'h0000_0000, q)
    firmware_event_enable_i <= 1'b0;
    $display("test lock release done");
    wr(1'b0, 4'h1, 32'h0000_0002);
    cpu_in_c3_i <= 1'b1;
    busmaster_req_i <= 1'b1;
    wait_on(2, 1'b1);
    `CHK("c3_wake_on", 1'b1, c3_wake_o)
    wr(1'b0, 4'h1, 32'h0000_0000);
    repeat (4) @(posedge core_clk_i);
    #1;
    `CHK("c3_wake_off", 1'b0, c3_wake_o)
    @(posedge core_clk_i);
    {busmaster_req_i, cpu_in_c3_i} <= 2'b00;
    $display("test bus master wake done");
    for (int t = 0; t < 8; t++) begin
      wr(1'b0, 4'h2, 32'h0000_2000 | (t << 10));
      wait_on(0, 1'b1);
      `CHK("sleep_type", t[2:0], sleep_type_o)
      wait_on(1, 1'b1);
      if (t == 5) begin
        rd(1'b1, 4'hF, t0);
        repeat (200) @(posedge core_clk_i);
        rd(1'b1, 4'hF, t1);
        `CHK("timer_in_sleep", t0, t1)
      end
      @(posedge core_clk_i);
      wake_i <= 1'b1;
      repeat (4) @(posedge core_clk_i);
      wake_i <= 1'b0;
      wait_on(1, 1'b0);
      rd(1'b0, 4'h3, q);
      `CHK("trigger_reads_zero", {16'h0000, 3'b000, t[2:0], 10'h000}, q)
    end
    $display("test sleep done");
    rd(1'b1, 4'hF, t0);
    repeat (280) @(posedge core_clk_i);
    rd(1'b1, 4'hF, t1);
    `CHK("timer_rate", 1'b1, (t1 - t0 >= 32'hA) && (t1 - t0 <= 32'hB))
    wr(1'b1, 4'hF, 32'hFFFF_FFFF);
    rd(1'b1, 4'hF, q);
    `CHK("timer_write_ignored", 1'b1, (q >= t1) && (q - t1 <= 32'h2))
    base_clk_run_i <= 1'b0;
    repeat (10) @(posedge core_clk_i);
    rd(1'b1, 4'hF, t0);
    repeat (200) @(posedge core_clk_i);
    rd(1'b1, 4'hF, t1);
    `CHK("timer_held", t0, t1)
    base_clk_run_i <= 1'b1;
    repeat (200) @(posedge core_clk_i);
    rd(1'b1, 4'hF, q);
    `CHK("timer_resumed", 1'b1, (q > t1) && (q - t1 <= 32'hA))
    $display("test timer done");
    rst_n_i <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    rd(1'b0, 4'h3, q);
    `CHK("ctrl_rereset", 32'h0000_0000, q)
    rd(1'b1, 4'hF, q);
    `CHK("timer_rereset", 32'h0000_0000, q)
    `CHK("carry_rereset", 1'b0, timer_carry_status_o)
    `CHK("fw_sts_rereset", 1'b0, firmware_event_status_o)
    timer_interrupt_enable_i <= 1'b1;
    timer_status_clr_i       <= 1'b1;
    @(posedge core_clk_i);
    timer_status_clr_i       <= 1'b0;
    #1;
    `CHK("carry_cleared", 1'b0, timer_carry_status_o)
    `CHK("timer_irq_idle", 1'b0, os_level_interrupt_o | firmware_management_interrupt_o)
    $display("test rereset done");
    tally_and_finish();
  end
endmodule : pm_control_and_timer_test
